// ===== src/flash_prog_pkg.sv
// Constants for the flash self-programming controller.
// Assumes a 100 MHz system clock and an 8-bit register port.
//
// Operation
// - Erase and write act on whole 32-word pages; read returns one word.
// - Write buffer holds exactly one 32-word page.
// - Successful unlock sequence raises the program-unlocked flag.
// - Buffer loads are taken only while the unlocked flag is high.
// - Write start bit stays high during a write, hardware clears it after.
// - Read runs only with read-allow set, launched by the read start bit.
// - Hardware clears the read start bit once the word is read.
// - Page is address bits 13 to 5; bits 4 to 0 pick the word.
// - High data byte write pushes the word, address steps, saturating at 31.
// - Op select codes: write 000, erase 001, read 011, unlock 110.
// - Buffer clears after a write, or on the self-clearing clear bit.
// - Time select 0: erase 3.2 ms, write 2.2 ms; 1: 3.7 ms, 3.0 ms.
package flash_prog_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int PAGE_WORDS    = 32;
  localparam int WIDX_W        = 5;
  localparam int FADDR_W       = 14;
  localparam int WORD_W        = 16;
  localparam int BYTE_W        = 8;
  localparam int RA_W          = 4;
  localparam int CNT_W         = 19;
  localparam int UCNT_W        = 16;

  // Register offsets
  localparam logic [RA_W-1:0] OFS_CTRL  = 4'h0;
  localparam logic [RA_W-1:0] OFS_CTRL2 = 4'h1;
  localparam logic [RA_W-1:0] OFS_ALO   = 4'h2;
  localparam logic [RA_W-1:0] OFS_AHI   = 4'h3;
  localparam logic [RA_W-1:0] OFS_DLO   = 4'h4;
  localparam logic [RA_W-1:0] OFS_DHI   = 4'h5;
  localparam logic [RA_W-1:0] OFS_KEY   = 4'h6;
  localparam logic [RA_W-1:0] OFS_KEYL  = 4'hB;

  // Control field positions
  localparam int B_UNLOCKED = 7;
  localparam int B_OP_HI    = 6;
  localparam int B_OP_LO    = 4;
  localparam int B_TRIG     = 3;
  localparam int B_WSTART   = 2;
  localparam int B_RDALLOW  = 1;
  localparam int B_RSTART   = 0;
  localparam int B_TSEL     = 1;
  localparam int B_CLR      = 0;

  localparam logic [2:0] OP_WRITE  = 3'h0;
  localparam logic [2:0] OP_ERASE  = 3'h1;
  localparam logic [2:0] OP_READ   = 3'h3;
  localparam logic [2:0] OP_UNLOCK = 3'h6;

  localparam logic [BYTE_W-1:0]  RST_BYTE  = 8'h00;
  localparam logic [WIDX_W-1:0]  LAST_WORD = 5'h1F;
  localparam logic [WORD_W-1:0]  KEY1_DEF  = 16'h5AA5;
  localparam logic [WORD_W-1:0]  KEY2_DEF  = 16'h3CC3;
  localparam logic [WORD_W-1:0]  KEY3_DEF  = 16'h0FF0;

  // Times in microseconds; unlock window in clock cycles
  localparam int ERASE_T0_US = 3200;
  localparam int WRITE_T0_US = 2200;
  localparam int ERASE_T1_US = 3700;
  localparam int WRITE_T1_US = 3000;
  localparam int UNLOCK_CYC  = 1024;

  function automatic int us_to_cyc(input int us);
    return (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction : us_to_cyc

  localparam int ERASE0_CYC = us_to_cyc(ERASE_T0_US);
  localparam int WRITE0_CYC = us_to_cyc(WRITE_T0_US);
  localparam int ERASE1_CYC = us_to_cyc(ERASE_T1_US);
  localparam int WRITE1_CYC = us_to_cyc(WRITE_T1_US);

endpackage : flash_prog_pkg

// ===== src/flash_self_program_ctrl.sv
// Flash self-programming controller: register port, page buffer, sequencer.
// Assumes a flash array that takes one word per write strobe and answers a
// read strobe with data in the same cycle as the strobe.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module flash_self_program_ctrl #(
  parameter int                 ERASE0_CYC = flash_prog_pkg::ERASE0_CYC,
  parameter int                 WRITE0_CYC = flash_prog_pkg::WRITE0_CYC,
  parameter int                 ERASE1_CYC = flash_prog_pkg::ERASE1_CYC,
  parameter int                 WRITE1_CYC = flash_prog_pkg::WRITE1_CYC,
  parameter int                 UNLOCK_CYC = flash_prog_pkg::UNLOCK_CYC,
  parameter logic [15:0]        KEY1       = flash_prog_pkg::KEY1_DEF,
  parameter logic [15:0]        KEY2       = flash_prog_pkg::KEY2_DEF,
  parameter logic [15:0]        KEY3       = flash_prog_pkg::KEY3_DEF
) (
  input  wire logic                                MCLK_IN,        // System clock
  input  wire logic                                RST_B_IN,       // Async reset, low
  input  wire logic [flash_prog_pkg::RA_W-1:0]     BUS_ADDR_IN,    // Register address
  input  wire logic [flash_prog_pkg::BYTE_W-1:0]   BUS_WDATA_IN,   // Write data
  input  wire logic                                BUS_WR_IN,      // Write strobe
  input  wire logic                                BUS_RD_IN,      // Read strobe
  output logic      [flash_prog_pkg::BYTE_W-1:0]   BUS_RDATA_OUT,  // Read data
  output logic      [flash_prog_pkg::FADDR_W-1:0]  FL_ADDR_OUT,    // Array word address
  output logic      [flash_prog_pkg::WORD_W-1:0]   FL_WDATA_OUT,   // Array write word
  output logic                                     FL_WE_OUT,      // Word program strobe
  output logic                                     FL_ERASE_OUT,   // Page erase level
  output logic                                     FL_RD_OUT,      // Word read strobe
  input  wire logic [flash_prog_pkg::WORD_W-1:0]   FL_RDATA_IN     // Array read word
);
  import flash_prog_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_LOAD, ST_PWAIT, ST_READ} state_t;

  typedef struct packed {
    logic                               unlocked;
    logic [2:0]                         op;
    logic                               trig;
    logic                               wstart;
    logic                               rd_allow;
    logic                               rstart;
    logic                               tsel;
    logic                               clr;
    logic [FADDR_W-1:0]                 addr;
    logic [BYTE_W-1:0]                  dlo;
    logic [BYTE_W-1:0]                  dhi;
    logic [2:0][BYTE_W-1:0]             klo;
    logic [1:0]                         kstage;
    logic [UCNT_W-1:0]                  ucnt;
    state_t                             st;
    logic [CNT_W-1:0]                   cnt;
    logic [WIDX_W-1:0]                  idx;
    logic [PAGE_WORDS-1:0][WORD_W-1:0]  mem;
    logic [BYTE_W-1:0]                  rdata;
    logic [FADDR_W-1:0]                 fl_addr;
    logic [WORD_W-1:0]                  fl_wdata;
    logic                               fl_we;
    logic                               fl_erase;
    logic                               fl_rd;
  } regs_t;

  localparam logic [2:0][WORD_W-1:0] KEYS = {KEY3, KEY2, KEY1};

  regs_t               s_r;
  regs_t               s_nxt;
  logic [BYTE_W-1:0]   rd_mux;
  logic                idle;
  logic [RA_W-1:0]     koff;
  logic [1:0]          ki;
  logic [2:0]          wop;

  assign idle = (s_r.st == ST_IDLE) && !s_r.clr;
  assign koff = BUS_ADDR_IN - OFS_KEY;
  assign ki   = koff[2:1];
  assign wop  = BUS_WDATA_IN[B_OP_HI:B_OP_LO];

  always_comb begin
    case (BUS_ADDR_IN)
      OFS_CTRL:  rd_mux = {s_r.unlocked, s_r.op, s_r.trig, s_r.wstart, s_r.rd_allow,
                           s_r.rstart};
      OFS_CTRL2: rd_mux = {6'h00, s_r.tsel, s_r.clr};
      OFS_ALO:   rd_mux = s_r.addr[7:0];
      OFS_AHI:   rd_mux = {2'h0, s_r.addr[FADDR_W-1:8]};
      OFS_DLO:   rd_mux = s_r.dlo;
      OFS_DHI:   rd_mux = s_r.dhi;
      default:   rd_mux = RST_BYTE;
    endcase
  end

  always_comb begin
    s_nxt          = s_r;
    s_nxt.fl_we    = 1'b0;
    s_nxt.fl_rd    = 1'b0;
    s_nxt.rdata    = BUS_RD_IN ? rd_mux : RST_BYTE;

    // Unlock window expiry
    if (s_r.trig) begin
      if (s_r.ucnt == '0) begin
        s_nxt.trig   = 1'b0;
        s_nxt.kstage = 2'h0;
      end else begin
        s_nxt.ucnt = s_r.ucnt - 1'b1;
      end
    end

    // Sequencer runs before the bus so software sets win over hardware clears
    case (s_r.st)
      ST_IDLE: begin
        if (s_r.clr) begin
          s_nxt.mem = '0;
          s_nxt.clr = 1'b0;
        end
      end
      ST_ERASE: begin
        if (s_r.cnt == '0) begin
          s_nxt.fl_erase = 1'b0;
          s_nxt.wstart   = 1'b0;
          s_nxt.st       = ST_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      ST_LOAD: begin
        s_nxt.fl_we    = 1'b1;
        s_nxt.fl_addr  = {s_r.addr[FADDR_W-1:WIDX_W], s_r.idx};
        s_nxt.fl_wdata = s_r.mem[s_r.idx];
        if (s_r.idx == LAST_WORD) begin
          s_nxt.st  = ST_PWAIT;
          s_nxt.cnt = s_r.tsel ? CNT_W'(WRITE1_CYC - 1) : CNT_W'(WRITE0_CYC - 1);
        end else begin
          s_nxt.idx = s_r.idx + 1'b1;
        end
      end
      ST_PWAIT: begin
        if (s_r.cnt == '0) begin
          s_nxt.mem    = '0;
          s_nxt.wstart = 1'b0;
          s_nxt.st     = ST_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      ST_READ: begin
        s_nxt.dlo    = FL_RDATA_IN[BYTE_W-1:0];
        s_nxt.dhi    = FL_RDATA_IN[WORD_W-1:BYTE_W];
        s_nxt.rstart = 1'b0;
        s_nxt.st     = ST_IDLE;
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    if (BUS_WR_IN) begin
      case (BUS_ADDR_IN)
        OFS_CTRL: begin
          if (!BUS_WDATA_IN[B_UNLOCKED]) begin
            s_nxt.unlocked = 1'b0;
          end
          s_nxt.op       = wop;
          s_nxt.rd_allow = BUS_WDATA_IN[B_RDALLOW];
          if (BUS_WDATA_IN[B_TRIG] && !s_r.trig && wop == OP_UNLOCK) begin
            s_nxt.trig   = 1'b1;
            s_nxt.ucnt   = UCNT_W'(UNLOCK_CYC - 1);
            s_nxt.kstage = 2'h0;
          end
          if (idle) begin
            if (BUS_WDATA_IN[B_WSTART] && s_r.unlocked && wop == OP_WRITE) begin
              s_nxt.wstart = 1'b1;
              s_nxt.idx    = '0;
              s_nxt.st     = ST_LOAD;
            end else if (BUS_WDATA_IN[B_WSTART] && s_r.unlocked && wop == OP_ERASE) begin
              s_nxt.wstart   = 1'b1;
              s_nxt.fl_erase = 1'b1;
              s_nxt.fl_addr  = {s_r.addr[FADDR_W-1:WIDX_W], 5'h00};
              s_nxt.cnt      = s_r.tsel ? CNT_W'(ERASE1_CYC - 1) : CNT_W'(ERASE0_CYC - 1);
              s_nxt.st       = ST_ERASE;
            end else if (BUS_WDATA_IN[B_RSTART] && s_r.rd_allow
                         && BUS_WDATA_IN[B_RDALLOW] && wop == OP_READ) begin
              s_nxt.rstart  = 1'b1;
              s_nxt.fl_rd   = 1'b1;
              s_nxt.fl_addr = s_r.addr;
              s_nxt.st      = ST_READ;
            end
          end
        end
        OFS_CTRL2: begin
          s_nxt.tsel = BUS_WDATA_IN[B_TSEL];
          if (BUS_WDATA_IN[B_CLR]) begin
            s_nxt.clr = 1'b1;
          end
        end
        OFS_ALO: begin
          if (s_r.st == ST_IDLE) begin
            s_nxt.addr[7:0] = BUS_WDATA_IN;
          end
        end
        OFS_AHI: begin
          if (s_r.st == ST_IDLE) begin
            s_nxt.addr[FADDR_W-1:8] = BUS_WDATA_IN[FADDR_W-9:0];
          end
        end
        OFS_DLO: s_nxt.dlo = BUS_WDATA_IN;
        OFS_DHI: begin
          s_nxt.dhi = BUS_WDATA_IN;
          if (s_r.unlocked && idle) begin
            s_nxt.mem[s_r.addr[WIDX_W-1:0]] = {BUS_WDATA_IN, s_r.dlo};
            if (s_r.addr[WIDX_W-1:0] != LAST_WORD) begin
              s_nxt.addr[WIDX_W-1:0] = s_r.addr[WIDX_W-1:0] + 1'b1;
            end
          end
        end
        default: begin
          if (BUS_ADDR_IN >= OFS_KEY && BUS_ADDR_IN <= OFS_KEYL) begin
            if (!koff[0]) begin
              s_nxt.klo[ki] = BUS_WDATA_IN;
            end else if (s_r.trig && s_r.kstage == ki
                         && {BUS_WDATA_IN, s_r.klo[ki]} == KEYS[ki]) begin
              s_nxt.kstage = s_r.kstage + 1'b1;
              if (ki == 2'h2) begin
                s_nxt.unlocked = 1'b1;
                s_nxt.trig     = 1'b0;
                s_nxt.kstage   = 2'h0;
              end
            end else begin
              s_nxt.kstage = 2'h0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s_r    <= '0;
      s_r.st <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign BUS_RDATA_OUT = s_r.rdata;
  assign FL_ADDR_OUT   = s_r.fl_addr;
  assign FL_WDATA_OUT  = s_r.fl_wdata;
  assign FL_WE_OUT     = s_r.fl_we;
  assign FL_ERASE_OUT  = s_r.fl_erase;
  assign FL_RD_OUT     = s_r.fl_rd;

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  a_page_stream: assert property (
    $rose(s_r.st == ST_LOAD) |=> s_r.fl_we [*8] ##1 s_r.st == ST_LOAD)
    else $error("page load stream broken");
  a_last_word: assert property (
    s_r.st == ST_LOAD && s_r.idx == LAST_WORD |=> s_r.st == ST_PWAIT && s_r.fl_we
      && s_r.fl_addr[WIDX_W-1:0] == LAST_WORD)
    else $error("page load did not end at word 31");
  a_unlock_set: assert property (
    BUS_WR_IN && BUS_ADDR_IN == OFS_KEYL && s_r.trig && s_r.kstage == 2'h2
      && {BUS_WDATA_IN, s_r.klo[2]} == KEY3 |=> s_r.unlocked && !s_r.trig)
    else $error("unlock flag not raised");
  a_locked_noload: assert property (
    BUS_WR_IN && BUS_ADDR_IN == OFS_DHI && !s_r.unlocked && idle |=> $stable(s_r.mem)
      && $stable(s_r.addr))
    else $error("buffer loaded while locked");
  a_write_busy: assert property (
    s_r.st == ST_LOAD || s_r.st == ST_PWAIT |-> s_r.wstart)
    else $error("write start low during write");
  a_read_gate: assert property (
    $rose(s_r.rstart) |-> s_r.fl_rd && s_r.rd_allow && s_r.op == OP_READ)
    else $error("read launched without allow");
  a_read_done: assert property (
    s_r.fl_rd && !(BUS_WR_IN && BUS_ADDR_IN == OFS_DHI)
      |=> !s_r.rstart && s_r.dhi == $past(FL_RDATA_IN[WORD_W-1:BYTE_W]))
    else $error("read start not cleared");
  a_page_addr: assert property (
    s_r.fl_we |-> s_r.fl_addr[FADDR_W-1:WIDX_W] == s_r.addr[FADDR_W-1:WIDX_W])
    else $error("program address outside page");
  a_addr_sat: assert property (
    BUS_WR_IN && BUS_ADDR_IN == OFS_DHI && s_r.unlocked && idle
      |=> s_r.addr[WIDX_W-1:0] == ($past(s_r.addr[WIDX_W-1:0]) == LAST_WORD ?
          LAST_WORD : $past(s_r.addr[WIDX_W-1:0]) + 5'h01))
    else $error("address step wrong");
  a_erase_mode: assert property (
    $rose(s_r.fl_erase) |-> s_r.op == OP_ERASE && s_r.wstart)
    else $error("erase without erase mode");
  a_buf_cleared: assert property (
    (s_r.st == ST_PWAIT && s_r.cnt == '0) || (s_r.st == ST_IDLE && s_r.clr)
      |=> s_r.mem == '0)
    else $error("buffer not cleared");
  a_erase_time: assert property (
    $rose(s_r.fl_erase) |-> s_r.cnt == (s_r.tsel ? CNT_W'(ERASE1_CYC - 1)
      : CNT_W'(ERASE0_CYC - 1)))
    else $error("erase time count wrong");
  a_no_restart: assert property (
    s_r.st == ST_ERASE && s_r.cnt != '0 |=> s_r.st == ST_ERASE && s_r.fl_erase)
    else $error("busy erase disturbed");

  c_page_write: cover property ($fell(s_r.wstart) && s_r.mem == '0);
  c_page_erase: cover property ($fell(s_r.fl_erase));
  c_word_read:  cover property ($fell(s_r.rstart));
  c_unlock:     cover property ($rose(s_r.unlocked));

endmodule : flash_self_program_ctrl

// ===== verification/flash_self_program_ctrl_test.sv
// Self-checking bench for the flash self-programming controller.
// Assumes flash_prog_pkg is compiled first; the bench plays both the
// register master and the flash array, with short timing parameters.
`timescale 1ns/1ps
module flash_self_program_ctrl_test;
  import flash_prog_pkg::*;
  localparam int E0 = 20;
  localparam int W0 = 15;
  localparam int E1 = 25;
  localparam int W1 = 18;
  logic                mclk;
  logic                rst_b;
  logic [RA_W-1:0]     addr;
  logic [BYTE_W-1:0]   wdata;
  logic                wr;
  logic                rd;
  logic [BYTE_W-1:0]   rdata;
  logic [FADDR_W-1:0]  fl_addr;
  logic [WORD_W-1:0]   fl_wdata;
  logic [WORD_W-1:0]   fl_rdata;
  logic                fl_we;
  logic                fl_erase;
  logic                fl_rd;
  int                  failures;
  int                  compares;
  int                  we_n;
  int                  erase_n;
  int                  rd_n;
  logic [FADDR_W-1:0]  we_addr [PAGE_WORDS];
  logic [WORD_W-1:0]   we_data [PAGE_WORDS];
  logic [FADDR_W-1:0]  rd_addr;
  logic [FADDR_W-1:0]  erase_addr;
  logic [BYTE_W-1:0]   v;

  flash_self_program_ctrl #(
    .ERASE0_CYC(E0), .WRITE0_CYC(W0), .ERASE1_CYC(E1), .WRITE1_CYC(W1), .UNLOCK_CYC(64)
  ) u_dut (
    .MCLK_IN(mclk), .RST_B_IN(rst_b), .BUS_ADDR_IN(addr), .BUS_WDATA_IN(wdata),
    .BUS_WR_IN(wr), .BUS_RD_IN(rd), .BUS_RDATA_OUT(rdata), .FL_ADDR_OUT(fl_addr),
    .FL_WDATA_OUT(fl_wdata), .FL_WE_OUT(fl_we), .FL_ERASE_OUT(fl_erase),
    .FL_RD_OUT(fl_rd), .FL_RDATA_IN(fl_rdata)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Flash-side monitor
  always @(posedge mclk) begin
    if (fl_we === 1'b1) begin
      if (we_n < PAGE_WORDS) begin
        we_addr[we_n] = fl_addr;
        we_data[we_n] = fl_wdata;
      end
      we_n++;
    end
    if (fl_erase === 1'b1) begin
      erase_addr = fl_addr;
      erase_n++;
    end
    if (fl_rd === 1'b1) begin
      rd_addr = fl_addr;
      rd_n++;
    end
  end

  task automatic complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk16

  task automatic chk_n(input string nm, input int e, input int g);
    compares++;
    if (g != e) begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_n

  task automatic bus_wr(input logic [RA_W-1:0] a, input logic [BYTE_W-1:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [RA_W-1:0] a, output logic [BYTE_W-1:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd

  task automatic zero_counts;
    @(negedge mclk);
    we_n    = 0;
    erase_n = 0;
    rd_n    = 0;
  endtask : zero_counts

  // Poll a control bit until hardware clears it
  task automatic wait_clear(input int b);
    logic [BYTE_W-1:0] c;
    int                i;
    for (i = 0; i < 300; i++) begin
      bus_rd(OFS_CTRL, c);
      if (c[b] === 1'b0) break;
    end
    if (i == 300) begin
      failures++;
      $display("wrong value start_bit_clear expected 0 seen %b", c[b]);
      complete_run;
    end
  endtask : wait_clear

  task automatic t_locked;
    bus_rd(OFS_CTRL, v);
    chk8("ctrl_reset", 8'h00, v);
    bus_rd(4'hC, v);
    chk8("unmapped_read", 8'h00, v);
    bus_wr(OFS_ALO, 8'h05);
    bus_wr(OFS_DLO, 8'h11);
    bus_wr(OFS_DHI, 8'h22);
    bus_rd(OFS_ALO, v);
    chk8("addr_low_locked", 8'h05, v);
    @(posedge mclk);
    #1 chk8("rdata_idle", 8'h00, rdata);
    $display("test locked done");
  endtask : t_locked

  task automatic t_unlock;
    bus_wr(OFS_CTRL, 8'h68);
    bus_wr(4'h6, KEY1_DEF[7:0]);
    bus_wr(4'h7, KEY1_DEF[15:8]);
    bus_wr(4'h8, KEY2_DEF[7:0]);
    bus_wr(4'h9, KEY2_DEF[15:8]);
    bus_wr(4'hA, KEY3_DEF[7:0]);
    bus_wr(4'hB, KEY3_DEF[15:8]);
    bus_rd(OFS_CTRL, v);
    chk8("unlocked_flag", 8'h80, v & 8'h88);
    $display("test unlock done");
  endtask : t_unlock

  task automatic t_erase(input logic tsel, input int exp, input logic retry);
    bus_wr(OFS_CTRL2, {6'h00, tsel, 1'b0});
    bus_wr(OFS_AHI, 8'h00);
    bus_wr(OFS_ALO, retry ? 8'h6A : 8'h60);
    zero_counts();
    bus_wr(OFS_CTRL, 8'h94);
    if (retry) begin
      repeat (4) @(posedge mclk);
      bus_wr(OFS_CTRL, 8'h94);
    end
    wait_clear(B_WSTART);
    chk_n("erase_cycles", exp, erase_n);
    chk16("erase_addr", 16'h0060, {2'b00, erase_addr});
    $display("test erase done");
  endtask : t_erase

  task automatic t_write;
    for (int i = 0; i < PAGE_WORDS; i++) begin
      bus_wr(OFS_DLO, 8'(i));
      bus_wr(OFS_DHI, 8'(8'hA0 + i));
    end
    bus_rd(OFS_ALO, v);
    chk8("addr_saturate", 8'h7F, v);
    zero_counts();
    bus_wr(OFS_CTRL, 8'h84);
    bus_rd(OFS_CTRL, v);
    chk8("wstart_busy", 8'h04, v & 8'h04);
    wait_clear(B_WSTART);
    chk_n("write_words", PAGE_WORDS, we_n);
    for (int i = 0; i < PAGE_WORDS; i++) begin
      chk16("we_addr", {2'b00, 9'd3, 5'(i)}, {2'b00, we_addr[i]});
      chk16("we_data", {8'(8'hA0 + i), 8'(i)}, we_data[i]);
    end
    zero_counts();
    bus_wr(OFS_CTRL, 8'h84);
    wait_clear(B_WSTART);
    chk_n("rewrite_words", PAGE_WORDS, we_n);
    for (int i = 0; i < PAGE_WORDS; i++) begin
      chk16("cleared_data", 16'h0000, we_data[i]);
    end
    bus_wr(OFS_DLO, 8'h55);
    bus_wr(OFS_DHI, 8'hAA);
    bus_wr(OFS_CTRL2, 8'h03);
    bus_rd(OFS_CTRL2, v);
    chk8("clear_self", 8'h02, v);
    zero_counts();
    bus_wr(OFS_CTRL, 8'h84);
    repeat (30 + W1) @(posedge mclk);
    bus_rd(OFS_CTRL, v);
    chk8("write_time_busy", 8'h04, v & 8'h04);
    bus_rd(OFS_CTRL, v);
    chk8("write_time_done", 8'h00, v & 8'h04);
    chk_n("cleared_words", PAGE_WORDS, we_n);
    for (int i = 0; i < PAGE_WORDS; i++) begin
      chk16("manual_clear", 16'h0000, we_data[i]);
    end
    $display("test write done");
  endtask : t_write

  task automatic t_read;
    @(posedge mclk);
    fl_rdata <= 16'hC35A;
    bus_wr(OFS_CTRL, 8'h80);
    zero_counts();
    bus_wr(OFS_CTRL, 8'hB1);
    repeat (4) @(posedge mclk);
    chk_n("read_refused", 0, rd_n);
    bus_wr(OFS_CTRL, 8'h82);
    bus_wr(OFS_CTRL, 8'hB3);
    wait_clear(B_RSTART);
    chk_n("read_words", 1, rd_n);
    chk16("read_addr", 16'h006A, {2'b00, rd_addr});
    bus_rd(OFS_DLO, v);
    chk8("read_low", 8'h5A, v);
    bus_rd(OFS_DHI, v);
    chk8("read_high", 8'hC3, v);
    $display("test read done");
  endtask : t_read

  initial begin
    repeat (100000) @(posedge mclk);
    failures++;
    $display("wrong value run_length expected done seen hang");
    complete_run;
  end

  initial begin
    rst_b    = 1'b0;
    addr     = '0;
    wdata    = '0;
    wr       = 1'b0;
    rd       = 1'b0;
    fl_rdata = '0;
    failures = 0;
    compares = 0;
    we_n     = 0;
    erase_n  = 0;
    rd_n     = 0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    t_locked();
    t_unlock();
    t_erase(1'b0, E0, 1'b0);
    t_write();
    t_erase(1'b1, E1, 1'b1);
    t_read();
    complete_run;
  end
endmodule : flash_self_program_ctrl_test
